// ---- hw/spfs_cfg.svh ----
// Offsets, reset values, command codes and window counts of the flash sequencer.
// Assumes inclusion by bare name from every file that needs these constants.
`ifndef SPFS_CFG_SVH
`define SPFS_CFG_SVH
`define SPFS_OFS_CTRL 8'h00
`define SPFS_OFS_PTR 8'h04
`define SPFS_OFS_OPND 8'h08
`define SPFS_OFS_INSTR 8'h0C
`define SPFS_OFS_LOAD 8'h10
`define SPFS_CTRL_RESET 8'h00
`define SPFS_LOCK_RESET 8'hFF
`define SPFS_CMD_REEN 5'h11
`define SPFS_CMD_LOCK 5'h09
`define SPFS_CMD_WRITE 5'h05
`define SPFS_CMD_ERASE 5'h03
`define SPFS_CMD_STORE 5'h01
`define SPFS_CMD_NONE 5'h00
`define SPFS_WIN_CYC 3'h4
`define SPFS_WIN_LAST 3'h1
`define SPFS_LD_MIN 3'h2
`define SPFS_INSTR_ST 0
`define SPFS_INSTR_LD 1
`define SPFS_IRQ_BIT 7
`define SPFS_BLB_HI 5
`define SPFS_BLB_LO 2
`define SPFS_HTRANS_ACT 1
`define SPFS_BLANK_WORD 16'hFFFF
`define SPFS_BLANK_BYTE 8'hFF
`endif

// ---- hw/spfs_pkg.sv ----
// Types shared by the flash sequencer: control register layout, states, flash port.
// Assumes nothing beyond a SystemVerilog compiler.
package spfs_pkg;
  typedef struct packed {
    logic irq_en;
    logic rww_busy;
    logic rsvd;
    logic rww_reen;
    logic lock_set;
    logic pg_wrt;
    logic pg_ers;
    logic st_en;
  } spfs_ctrl_t;

  typedef enum logic [1:0] {
    SPFS_IDLE = 2'b00,
    SPFS_ERASE = 2'b01,
    SPFS_WRITE = 2'b10
  } spfs_state_t;

  typedef struct packed {
    logic erase;
    logic write;
    logic wvalid;
    logic [15:0] addr;
    logic [15:0] wdata;
  } spfs_flash_t;
endpackage

// ---- hw/spfs_top.sv ----
// Self-programming flash sequencer with an AHB-Lite register slave.
// Assumes one clock, a flash macro that follows the erase/write levels,
// and fuse levels arriving from pins outside the clock domain.
//
// How it works
// [R1] Lock-set command plus store sets boot lock bits from the low operand.
// [R2] Lock-set select clears after the lock set or after an unused window.
// [R3] Load within three cycles of lock-set returns lock or fuse byte.
// [R4] Page-write command plus store programs the buffer into the pointed page.
// [R5] Page-write select clears when writing ends or the window expires.
// [R6] Page-erase command plus store erases the page from the pointer.
// [R7] Page-erase select clears when erasing ends or the window expires.
// [R8] CPU is halted during erase or write of a no-READ_WHILE_WRITE_SECTION page.
// [R9] READ_WHILE_WRITE_SECTION section reads are blocked while it is being programmed.
// [R10] A store outside the four-cycle window does nothing.
// [R11] Plain store enable puts the operand word into the page buffer.
// [R12] Store enable clears after store or timeout, stays up while programming.
// [R13] Only five command patterns in the low bits are accepted.
// [R14] Pointer splits into word and page; the page is latched at start.
// [R15] Loads address bytes, using the pointer's lowest bit too.
// [R16] Page buffer is wiped after page write, read re-enable, and reset.
// [R17] Software writes each buffer word once between wipes.
// [R18] An EEPROM write during page loading discards the buffer.
// [R19] READ_WHILE_WRITE_SECTION busy flag stays set while the READ_WHILE_WRITE_SECTION section is programmed.
// [R20] Ready interrupt stays asserted while enabled and store enable is low.
// [R21] Software clears the busy flag via read re-enable before READ_WHILE_WRITE_SECTION access.
// [R22] Software gives only the page number, same for erase and write.
// [R23] Read re-enable plus store after programming makes READ_WHILE_WRITE_SECTION readable again.
// [R24] Busy flag sets at READ_WHILE_WRITE_SECTION programming start and clears on page load.
// [R25] A window counter restarts on each accepted write and clears unused commands.
`include "spfs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module spfs_top #(
  parameter int PAGE_WORDS = 32,
  parameter int NO_RWW_SECTION_FIRST_PAGE = 96,
  parameter int PROG_CYCLES = 1024
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic eeprom_write,
  input wire logic [7:0] fuse_pins,
  input wire logic [7:0] flash_rd_byte,
  output var spfs_pkg::spfs_flash_t flash_o,
  output logic [15:0] load_addr,
  output logic cpu_halt,
  output logic rww_read_block,
  output logic store_ready_irq
);
  import spfs_pkg::*;

  localparam int WI = $clog2(PAGE_WORDS);
  localparam int PGW = 15 - WI;
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);
  localparam logic [WI:0] STRM_END = (WI + 1)'(PAGE_WORDS);
  localparam logic [PGW-1:0] NO_RWW_SECTION_PAGE = PGW'(NO_RWW_SECTION_FIRST_PAGE);

  // -------------------------------------------------------------------------
  // Parameter checks
  // -------------------------------------------------------------------------
  // The buffer index must be a clean power of two and leave room for pages.
  if (PAGE_WORDS < 2 || (1 << WI) != PAGE_WORDS || WI > 8 ||
      NO_RWW_SECTION_FIRST_PAGE >= (1 << PGW) || PROG_CYCLES <= PAGE_WORDS) begin : g_chk
    $error("spfs_top: unsupported parameter set");
  end

  spfs_ctrl_t ctrl_reg;
  spfs_state_t state_reg;
  logic [15:0] ptr_reg;
  logic [15:0] opnd_reg;
  logic [7:0] lock_reg;
  logic [7:0] load_reg;
  logic [2:0] cnt_reg;
  logic [CW-1:0] prog_cnt_reg;
  logic [PGW-1:0] page_reg;
  logic [WI:0] strm_reg;
  logic op_no_rww_section_reg;
  logic [7:0] fuse_m_reg;
  logic [7:0] fuse_s_reg;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_vld_reg;
  logic ap_valid_reg;
  logic ap_write_reg;
  logic [7:0] ap_addr_reg;
  logic [31:0] rd_word;

  // -------------------------------------------------------------------------
  // AHB-Lite slave
  // -------------------------------------------------------------------------
  // Zero wait states; every response is OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // The address phase is kept so the write lands with hwdata in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
    end else if (hready) begin
      ap_valid_reg <= hsel & htrans[`SPFS_HTRANS_ACT];
      ap_write_reg <= hwrite;
      ap_addr_reg <= haddr[7:0];
    end
  end

  wire logic wr_go = ap_valid_reg & ap_write_reg & hready;
  wire logic ctrl_wr = wr_go && ap_addr_reg == `SPFS_OFS_CTRL;
  wire logic ptr_wr = wr_go && ap_addr_reg == `SPFS_OFS_PTR;
  wire logic opnd_wr = wr_go && ap_addr_reg == `SPFS_OFS_OPND;
  wire logic instr_wr = wr_go && ap_addr_reg == `SPFS_OFS_INSTR;
  wire logic st_go = instr_wr & hwdata[`SPFS_INSTR_ST];
  wire logic ld_go = instr_wr & hwdata[`SPFS_INSTR_LD];

  // Read mux; the map repeats every 256 bytes and unmapped words read zero.
  always_comb begin
    rd_word = 32'h00000000;
    case (haddr[7:0])
      `SPFS_OFS_CTRL: rd_word = {24'h000000, ctrl_reg};
      `SPFS_OFS_PTR: rd_word = {16'h0000, ptr_reg};
      `SPFS_OFS_OPND: rd_word = {16'h0000, opnd_reg};
      `SPFS_OFS_LOAD: rd_word = {24'h000000, load_reg};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read data is captured at the address edge so it stands for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[`SPFS_HTRANS_ACT] && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // Pointer and operand registers are plain storage.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_reg <= 16'h0000;
      opnd_reg <= 16'h0000;
    end else begin
      if (ptr_wr) begin
        ptr_reg <= hwdata[15:0];
      end
      if (opnd_wr) begin
        opnd_reg <= hwdata[15:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Command decode
  // -------------------------------------------------------------------------
  wire logic [4:0] wcmd = hwdata[4:0];
  wire logic idle = state_reg == SPFS_IDLE;
  // A command write during programming is refused so store enable keeps its meaning; irq_en is still written.
  wire logic cmd_ok = ctrl_wr & idle &
    (wcmd == `SPFS_CMD_REEN || wcmd == `SPFS_CMD_LOCK || // R13
     wcmd == `SPFS_CMD_WRITE || wcmd == `SPFS_CMD_ERASE ||
     wcmd == `SPFS_CMD_STORE);
  wire logic st_ok = st_go & (cnt_reg != 3'h0) & idle & ctrl_reg.st_en; // R10
  wire logic start_ers = st_ok & ctrl_reg.pg_ers;
  wire logic start_wrt = st_ok & ctrl_reg.pg_wrt;
  wire logic do_lock = st_ok & ctrl_reg.lock_set;
  wire logic do_reen = st_ok & ctrl_reg.rww_reen;
  wire logic do_word = st_ok & ~ctrl_reg.pg_ers & ~ctrl_reg.pg_wrt &
    ~ctrl_reg.lock_set & ~ctrl_reg.rww_reen;
  wire logic ld_lock = ld_go & ctrl_reg.lock_set & ctrl_reg.st_en &
    (cnt_reg >= `SPFS_LD_MIN); // R3
  wire logic op_done = ~idle & (prog_cnt_reg == {CW{1'b0}});
  // A fresh command landing on the expiry edge restarts the window and must survive.
  wire logic expire = (cnt_reg == `SPFS_WIN_LAST) & ~st_ok & ~cmd_ok & idle; // R25
  wire logic [PGW-1:0] ptr_page = ptr_reg[15:WI+1];
  wire logic [WI-1:0] ptr_word = ptr_reg[WI:1];
  wire logic ptr_no_rww_section = ptr_page >= NO_RWW_SECTION_PAGE;

  // Window counter: loaded by each accepted command, emptied when used.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 3'h0;
    end else if (cmd_ok) begin
      cnt_reg <= `SPFS_WIN_CYC; // R25
    end else if (st_ok || ld_lock) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  // Control register; the busy flag set comes last so it wins any tie.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `SPFS_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg.irq_en <= hwdata[`SPFS_IRQ_BIT];
      end
      if (cmd_ok) begin
        {ctrl_reg.rww_reen, ctrl_reg.lock_set, ctrl_reg.pg_wrt,
         ctrl_reg.pg_ers, ctrl_reg.st_en} <= wcmd; // R13
      end
      if (do_lock || do_reen || do_word || ld_lock) begin
        {ctrl_reg.rww_reen, ctrl_reg.lock_set, ctrl_reg.pg_wrt,
         ctrl_reg.pg_ers, ctrl_reg.st_en} <= `SPFS_CMD_NONE; // R2 R12
      end
      if (op_done || expire) begin
        {ctrl_reg.rww_reen, ctrl_reg.lock_set, ctrl_reg.pg_wrt,
         ctrl_reg.pg_ers, ctrl_reg.st_en} <= `SPFS_CMD_NONE; // R5 R7 R25
      end
      if (do_reen || do_word) begin
        ctrl_reg.rww_busy <= 1'b0; // R23 R24
      end
      if ((start_ers || start_wrt) && !ptr_no_rww_section) begin
        ctrl_reg.rww_busy <= 1'b1; // R24 R19
      end
      ctrl_reg.rsvd <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Programming sequence
  // -------------------------------------------------------------------------
  // The page is latched at start so software may reuse the pointer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SPFS_IDLE;
      prog_cnt_reg <= {CW{1'b0}};
      page_reg <= {PGW{1'b0}};
      op_no_rww_section_reg <= 1'b0;
      cpu_halt <= 1'b0;
      strm_reg <= {(WI + 1){1'b0}};
    end else begin
      case (state_reg)
        SPFS_IDLE: begin
          if (start_ers || start_wrt) begin
            state_reg <= start_ers ? SPFS_ERASE : SPFS_WRITE; // R4 R6
            prog_cnt_reg <= PROG_LAST;
            page_reg <= ptr_page; // R14
            op_no_rww_section_reg <= ptr_no_rww_section;
            cpu_halt <= ptr_no_rww_section; // R8
            strm_reg <= {(WI + 1){1'b0}};
          end
        end
        SPFS_ERASE, SPFS_WRITE: begin
          if (prog_cnt_reg == {CW{1'b0}}) begin
            state_reg <= SPFS_IDLE;
            cpu_halt <= 1'b0;
          end else begin
            prog_cnt_reg <= prog_cnt_reg - {{(CW - 1){1'b0}}, 1'b1};
          end
          if (strm_reg != STRM_END) begin
            strm_reg <= strm_reg + {{WI{1'b0}}, 1'b1};
          end
        end
        default: begin
          state_reg <= SPFS_IDLE;
        end
      endcase
    end
  end

  // Page buffer: wipes first, a store afterwards, so a same-cycle store survives.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_vld_reg <= {PAGE_WORDS{1'b0}}; // R16
    end else begin
      if ((state_reg == SPFS_WRITE && op_done) ||
          (cmd_ok && wcmd == `SPFS_CMD_REEN)) begin
        buf_vld_reg <= {PAGE_WORDS{1'b0}}; // R16
      end
      if (eeprom_write && |buf_vld_reg) begin
        buf_vld_reg <= {PAGE_WORDS{1'b0}}; // R18
      end
      if (do_word) begin
        buf_vld_reg[ptr_word] <= 1'b1; // R11
      end
    end
  end

  // Buffer data has no reset; the valid bits decide what is real.
  always_ff @(posedge hclk) begin
    if (do_word) begin
      buf_mem[ptr_word] <= opnd_reg; // R11 R14
    end
  end

  // Flash macro levels; unloaded words stream out as blank.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_o <= '0;
    end else begin
      flash_o.erase <= state_reg == SPFS_ERASE;
      flash_o.write <= state_reg == SPFS_WRITE;
      flash_o.wvalid <= state_reg == SPFS_WRITE && strm_reg != STRM_END; // R4
      flash_o.addr <= {page_reg, strm_reg[WI-1:0], 1'b0};
      flash_o.wdata <= buf_vld_reg[strm_reg[WI-1:0]] ?
        buf_mem[strm_reg[WI-1:0]] : `SPFS_BLANK_WORD;
    end
  end

  // -------------------------------------------------------------------------
  // Lock bits, loads and status outputs
  // -------------------------------------------------------------------------
  // Programming can only clear lock bits, never set them back.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_reg <= `SPFS_LOCK_RESET;
    end else if (do_lock) begin
      lock_reg[`SPFS_BLB_HI:`SPFS_BLB_LO] <= lock_reg[`SPFS_BLB_HI:`SPFS_BLB_LO] &
        opnd_reg[`SPFS_BLB_HI:`SPFS_BLB_LO]; // R1
    end
  end

  // Fuse levels come from pins and pass two flip-flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_m_reg <= 8'h00;
      fuse_s_reg <= 8'h00;
    end else begin
      fuse_m_reg <= fuse_pins;
      fuse_s_reg <= fuse_m_reg;
    end
  end

  // A blocked READ_WHILE_WRITE_SECTION byte reads as blank instead of stale array data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_reg <= 8'h00;
    end else if (ld_lock) begin
      load_reg <= ptr_reg[0] ? lock_reg : fuse_s_reg; // R3 R15
    end else if (ld_go) begin
      load_reg <= (ctrl_reg.rww_busy && !ptr_no_rww_section) ? `SPFS_BLANK_BYTE :
        flash_rd_byte; // R9 R15
    end
  end

  // The interrupt lags store enable by one cycle to keep the output registered.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      store_ready_irq <= 1'b0;
    end else begin
      store_ready_irq <= ctrl_reg.irq_en & ~ctrl_reg.st_en; // R20
    end
  end

  assign load_addr = ptr_reg; // R15
  assign rww_read_block = ctrl_reg.rww_busy; // R9

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  property p_win_expire;
    @(posedge hclk) disable iff (!hresetn)
    cmd_ok ##1 (!instr_wr && !ctrl_wr)[*4] |=> (ctrl_reg[4:0] == 5'h00);
  endproperty
  a_win_expire: assert property (p_win_expire) // R25
    else $error("command bits survived an unused window");

  property p_late_store;
    @(posedge hclk) disable iff (!hresetn)
    (st_go && cnt_reg == 3'h0 && idle) |=> (state_reg == SPFS_IDLE) && $stable(buf_vld_reg);
  endproperty
  a_late_store: assert property (p_late_store) // R10
    else $error("store outside the window had an effect");

  property p_erase_start;
    @(posedge hclk) disable iff (!hresetn)
    start_ers |=> (state_reg == SPFS_ERASE) && (page_reg == $past(ptr_reg[15:WI+1]));
  endproperty
  a_erase_start: assert property (p_erase_start) // R6
    else $error("page erase did not start on the latched page");

  property p_en_held;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg != SPFS_IDLE) |-> ctrl_reg.st_en;
  endproperty
  a_en_held: assert property (p_en_held) // R12
    else $error("store enable dropped during programming");

  property p_halt;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg != SPFS_IDLE) |-> (cpu_halt == op_no_rww_section_reg);
  endproperty
  a_halt: assert property (p_halt) // R8
    else $error("cpu halt does not follow the section being programmed");

  property p_busy;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg != SPFS_IDLE && !op_no_rww_section_reg) |-> ctrl_reg.rww_busy && rww_read_block;
  endproperty
  a_busy: assert property (p_busy) // R19
    else $error("rww busy low while rww section is programmed");

  property p_wipe_after_write;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == SPFS_WRITE && op_done) |=> (buf_vld_reg == '0) && idle;
  endproperty
  a_wipe_after_write: assert property (p_wipe_after_write) // R16
    else $error("page buffer not wiped after page write");

  property p_eeprom_discard;
    @(posedge hclk) disable iff (!hresetn)
    (eeprom_write && !do_word) |=> (buf_vld_reg == '0);
  endproperty
  a_eeprom_discard: assert property (p_eeprom_discard) // R18
    else $error("eeprom write left loaded words in the buffer");

  property p_lock_set;
    @(posedge hclk) disable iff (!hresetn)
    do_lock |=> (lock_reg[5:2] == ($past(lock_reg[5:2]) & $past(opnd_reg[5:2])))
      && (ctrl_reg.lock_set == 1'b0);
  endproperty
  a_lock_set: assert property (p_lock_set) // R1
    else $error("lock bits not set from the low operand");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    (ctrl_reg.irq_en && !ctrl_reg.st_en) [*2] |-> store_ready_irq;
  endproperty
  a_irq: assert property (p_irq) // R20
    else $error("ready interrupt missing while store enable is low");

endmodule // spfs_top

`default_nettype wire

// ---- tb/spfs_flash_model.sv ----
// Flash array model for the sequencer bench: takes erase/write levels, serves load bytes.
// Assumes the flash port struct of the package and 32-word pages.
`timescale 1ns/1ns
`default_nettype none

module spfs_flash_model #(
  parameter int WORD_BITS = 5
) (
  input wire logic hclk,
  input wire spfs_pkg::spfs_flash_t flash_o,
  input wire logic [15:0] load_addr,
  output logic [7:0] flash_rd_byte
);
  import spfs_pkg::*;
  // ----------------------------------------
  // Array and bookkeeping
  // ----------------------------------------
  logic [15:0] mem [0:32767];
  logic [9:0] erased_page;
  logic [15:0] rd_word;

  // Start from zero, not blank, so that an erase is visible in the array.
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
    erased_page = 10'h000;
  end

  // Erase blanks the latched page; write stores one word per valid cycle.
  always @(posedge hclk) begin
    if (flash_o.erase) begin
      erased_page <= flash_o.addr[15:6];
      for (int i = 0; i < (1 << WORD_BITS); i++) mem[{flash_o.addr[15:6], i[4:0]}] <= 16'hFFFF;
    end
    if (flash_o.write && flash_o.wvalid) mem[flash_o.addr[15:1]] <= flash_o.wdata;
  end

  // Byte reads are little-endian within a word.
  assign rd_word = mem[load_addr[15:1]];
  assign flash_rd_byte = load_addr[0] ? rd_word[15:8] : rd_word[7:0];
endmodule // spfs_flash_model

`default_nettype wire

// ---- tb/test_self_program_flash_sequencer.sv ----
// Directed bench for the flash sequencer: bus tasks and command sequences with expectations.
// Assumes the flash model file and the design built with a short programming time.
`include "spfs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module test_self_program_flash_sequencer;
  import spfs_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic eeprom_write = 1'b0;
  logic [7:0] fuse_pins = 8'h5C;
  logic [7:0] flash_rd_byte;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cpu_halt, rww_read_block, store_ready_irq;
  logic [15:0] load_addr;
  spfs_flash_t flash_o;
  int n_fail = 0;
  int checks_done = 0;

  spfs_top #(.PAGE_WORDS(32), .NO_RWW_SECTION_FIRST_PAGE(96), .PROG_CYCLES(40)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .eeprom_write(eeprom_write), .fuse_pins(fuse_pins),
    .flash_rd_byte(flash_rd_byte), .flash_o(flash_o), .load_addr(load_addr),
    .cpu_halt(cpu_halt), .rww_read_block(rww_read_block), .store_ready_irq(store_ready_irq));

  spfs_flash_model u_flash (.hclk(hclk), .flash_o(flash_o), .load_addr(load_addr),
    .flash_rd_byte(flash_rd_byte));

  // Clock of 4 ns period.
  always #2 hclk = ~hclk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single transfer; the master never assumes a wait-state count.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(nm, x, e);
  endtask

  // Control write, d idle cycles, then the instruction write (1 store, 2 load).
  task automatic cmd(input logic [7:0] c, input int d, input logic [1:0] ins);
    wr(`SPFS_OFS_CTRL, {24'h0, c});
    repeat (d) @(posedge hclk);
    wr(`SPFS_OFS_INSTR, {30'h0, ins});
  endtask

  task automatic ld_chk(input string nm, input logic [15:0] p, input logic [7:0] e);
    wr(`SPFS_OFS_PTR, {16'h0, p});
    wr(`SPFS_OFS_INSTR, 32'h2);
    rd_chk(nm, `SPFS_OFS_LOAD, {24'h0, e});
  endtask

  // Polls the control register until store enable drops, bounded.
  task automatic wait_idle();
    logic [31:0] x;
    int n;
    n = 0;
    x = 32'h1;
    while (x[0] !== 1'b0 && n < 100) begin
      bus(1'b0, `SPFS_OFS_CTRL, 32'h0, x);
      n++;
    end
    // A poll that runs out counts as a mismatch.
    check("idle wait", {31'h0, x[0]}, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the expected few hundred cycles.
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd_chk("ctrl reset", `SPFS_OFS_CTRL, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    wr(`SPFS_OFS_CTRL, 32'h07);
    rd_chk("bad pattern", `SPFS_OFS_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      logic [7:0] c;
      c = (i == 0) ? 8'h03 : (i == 1) ? 8'h05 : (i == 2) ? 8'h09 : (i == 3) ? 8'h11 : 8'h01;
      wr(`SPFS_OFS_CTRL, {24'h0, c});
      rd_chk("cmd taken", `SPFS_OFS_CTRL, {24'h0, c});
      repeat (3) @(posedge hclk);
      rd_chk("cmd expired", `SPFS_OFS_CTRL, 32'h0);
    end
    wr(`SPFS_OFS_PTR, 32'h40);
    wr(`SPFS_OFS_OPND, 32'hDEAD);
    cmd(8'h01, 3, 2'h1);
    rd_chk("late store", `SPFS_OFS_CTRL, 32'h0);
    wr(`SPFS_OFS_PTR, 32'h47);
    wr(`SPFS_OFS_OPND, 32'hA55A);
    cmd(8'h01, 2, 2'h1);
    rd_chk("store done", `SPFS_OFS_CTRL, 32'h0);
    wr(`SPFS_OFS_PTR, 32'h7E);
    wr(`SPFS_OFS_OPND, 32'h1234);
    cmd(8'h01, 0, 2'h1);
    wr(`SPFS_OFS_PTR, 32'h40);
    cmd(8'h03, 0, 2'h1);
    rd_chk("erasing", `SPFS_OFS_CTRL, 32'h43);
    check("halt rww", {31'h0, cpu_halt}, 32'h0);
    check("block", {31'h0, rww_read_block}, 32'h1);
    wr(`SPFS_OFS_PTR, 32'h1800);
    wait_idle();
    check("erased page", {22'h0, u_flash.erased_page}, 32'h1);
    check("blank", {16'h0, u_flash.mem[32]}, 32'hFFFF);
    rd_chk("erase end", `SPFS_OFS_CTRL, 32'h40);
    wr(`SPFS_OFS_PTR, 32'h40);
    cmd(8'h05, 0, 2'h1);
    wait_idle();
    check("word3", {16'h0, u_flash.mem[35]}, 32'hA55A);
    check("word31", {16'h0, u_flash.mem[63]}, 32'h1234);
    check("word0", {16'h0, u_flash.mem[32]}, 32'hFFFF);
    ld_chk("blocked", 16'h46, 8'hFF);
    wr(`SPFS_OFS_PTR, 32'h80);
    wr(`SPFS_OFS_OPND, 32'h1111);
    cmd(8'h01, 0, 2'h1);
    rd_chk("load clears busy", `SPFS_OFS_CTRL, 32'h0);
    ld_chk("low byte", 16'h46, 8'h5A);
    ld_chk("high byte", 16'h47, 8'hA5);
    @(posedge hclk);
    eeprom_write <= 1'b1;
    @(posedge hclk);
    eeprom_write <= 1'b0;
    wr(`SPFS_OFS_PTR, 32'h82);
    wr(`SPFS_OFS_OPND, 32'h2222);
    cmd(8'h01, 0, 2'h1);
    wr(`SPFS_OFS_PTR, 32'h80);
    cmd(8'h05, 0, 2'h1);
    wait_idle();
    check("discarded", {16'h0, u_flash.mem[64]}, 32'hFFFF);
    check("kept", {16'h0, u_flash.mem[65]}, 32'h2222);
    cmd(8'h05, 0, 2'h1);
    wait_idle();
    check("wiped", {16'h0, u_flash.mem[65]}, 32'hFFFF);
    cmd(8'h11, 0, 2'h1);
    rd_chk("reenabled", `SPFS_OFS_CTRL, 32'h0);
    wr(`SPFS_OFS_PTR, 32'h1800);
    cmd(8'h03, 0, 2'h1);
    rd_chk("no_rww_section erase", `SPFS_OFS_CTRL, 32'h03);
    check("halt", {31'h0, cpu_halt}, 32'h1);
    check("no block", {31'h0, rww_read_block}, 32'h0);
    wait_idle();
    check("halt end", {31'h0, cpu_halt}, 32'h0);
    wr(`SPFS_OFS_OPND, 32'h0);
    cmd(8'h09, 0, 2'h1);
    rd_chk("lock set", `SPFS_OFS_CTRL, 32'h0);
    wr(`SPFS_OFS_PTR, 32'h1);
    cmd(8'h09, 0, 2'h2);
    rd_chk("lock bits", `SPFS_OFS_LOAD, 32'hC3);
    wr(`SPFS_OFS_PTR, 32'h0);
    cmd(8'h09, 1, 2'h2);
    rd_chk("fuse bits", `SPFS_OFS_LOAD, 32'h5C);
    wr(8'h14, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h14, 32'h0);
    wr(`SPFS_OFS_CTRL, 32'h80);
    rd_chk("irq enable", `SPFS_OFS_CTRL, 32'h80);
    check("irq on", {31'h0, store_ready_irq}, 32'h1);
    wr(`SPFS_OFS_CTRL, 32'h81);
    repeat (2) @(posedge hclk);
    check("irq off", {31'h0, store_ready_irq}, 32'h0);
    repeat (4) @(posedge hclk);
    check("irq back", {31'h0, store_ready_irq}, 32'h1);
    report_and_stop();
  end
endmodule // test_self_program_flash_sequencer

`default_nettype wire
